// >>> bench/pfs_sec_model.sv
// model: one secondary switch sharing the sync line
`timescale 1ns/1ps
module pfs_sec_model (
	input  wire logic clk,       // system clock
	input  wire logic line,      // resolved line level
	input  wire logic fault_cmd, // secondary sees a fault
	output logic      pull,      // pull-down enable
	output logic      sec_fet    // secondary fet state
);
	// pulls the line while its fault lasts; the bench decides when it releases
	always_ff @(posedge clk)
	begin
		pull    <= fault_cmd;
		sec_fet <= line && !fault_cmd;
	end
endmodule : pfs_sec_model

// >>> bench/pfs_sync_line_assertions.sv
// checker: port-level properties of the sync line block
`timescale 1ns/1ps
module pfs_sync_line_assertions
	import pfs_pkg::*;
(
	input wire logic       clk,            // system clock
	input wire logic       sys_rst,        // sync reset
	input wire logic       io3_in,         // line level
	input wire logic       io3_out,        // pin drive value
	input wire logic       io3_oe,         // pull-down enable
	input wire logic [1:0] io3_fn_wr_data, // new pin function
	input wire logic       io3_fn_wr,      // function write
	input wire logic [1:0] io3_fn,         // pin function
	input wire logic [7:0] ref_wr_data,    // reference data
	input wire logic       ref_wr,         // reference write
	input wire logic [7:0] shared_current_reference_setting, // dac code
	input wire logic       en_ok,          // enable
	input wire logic       fault_clear,    // latch clear
	input wire logic       fet_on,         // fet command
	input wire logic       ext_fault       // external fault latch
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	drive_low_a: assert property (io3_out == 1'b0)
		else $error("pin drive value not low");
	oe_fet_a: assert property ((io3_fn == PFS_FN_SYNC) [*2] ##0 fet_on |-> !io3_oe)
		else $error("pull-down disagrees with fet");
	line_off_a: assert property ((io3_fn == PFS_FN_SYNC && !io3_in) [*5] |-> !fet_on)
		else $error("fet on with line low");
	dis_off_a: assert property ((!en_ok && io3_fn == PFS_FN_SYNC) [*5] |-> !fet_on && io3_oe)
		else $error("disabled but not off");
	ext_hold_a: assert property (ext_fault && !fault_clear |=> ext_fault && !fet_on)
		else $error("external fault not held");
	ext_line_a: assert property ((io3_fn == PFS_FN_SYNC && ext_fault) [*2] |-> io3_oe)
		else $error("external fault without pull-down");
	fn_wr_a: assert property (io3_fn_wr |=> io3_fn == $past(io3_fn_wr_data))
		else $error("pin function write lost");
	fn_keep_a: assert property (!io3_fn_wr |=> $stable(io3_fn))
		else $error("pin function changed alone");
	ref_wr_a: assert property (ref_wr |=> shared_current_reference_setting == $past(ref_wr_data))
		else $error("reference write lost");
	on_cause_a: assert property ($rose(fet_on) |-> !ext_fault && $past(en_ok, 2))
		else $error("turn-on without cause");
	c_on: cover property ($rose(fet_on));
	c_ext: cover property ($rose(ext_fault));
	c_fn: cover property (io3_fn_wr);
endmodule : pfs_sync_line_assertions

bind pfs_sync_line pfs_sync_line_assertions chk (.clk(clk), .sys_rst(sys_rst),
	.io3_in(io3_in), .io3_out(io3_out), .io3_oe(io3_oe), .io3_fn_wr_data(io3_fn_wr_data),
	.io3_fn_wr(io3_fn_wr), .io3_fn(io3_fn), .ref_wr_data(ref_wr_data), .ref_wr(ref_wr),
	.shared_current_reference_setting(shared_current_reference_setting), .en_ok(en_ok),
	.fault_clear(fault_clear), .fet_on(fet_on), .ext_fault(ext_fault));

// >>> bench/pfs_sync_line_tb.sv
// testbench: directed scenarios for the sync line block
`timescale 1ns/1ps
module pfs_sync_line_tb;
	import pfs_pkg::*;
	logic clk = 0, sys_rst = 1, fn_wr = 0, gpo = 1, ref_wr = 0, oc = 0, ft = 0, clr = 0;
	logic sec_cmd = 0, lf = 0, prim = 1;
	logic [1:0] fn_d = 0;
	logic [7:0] ref_d = 0;
	logic [15:0] cfg = 0;
	logic [6:0] offv = 7'h40;
	logic out_w, oe, gpi, fet, ext, sec_pull, line, sec_f;
	logic [1:0] fn;
	logic [7:0] refv;
	int failures = 0, samples_checked = 0;
	// pull-up makes the high level; any pull-down wins
	assign line = !(oe || sec_pull);
	initial forever #50 clk = ~clk;
	pfs_sync_line #(.OC_BLANK(8), .FT_SHOT(4), .FT_OFF(2)) uut (.clk(clk), .sys_rst(sys_rst),
		.is_primary(prim), .io3_in(line), .io3_out(out_w), .io3_oe(oe), .io3_fn_wr_data(fn_d),
		.io3_fn_wr(fn_wr), .io3_fn(fn), .io3_gpo(gpo), .io3_gpi(gpi), .cfg_word(cfg),
		.ref_wr_data(ref_d), .ref_wr(ref_wr), .shared_current_reference_setting(refv),
		.en_ok(!offv[6]), .ot_flag(offv[0]), .retry_run(offv[1]), .uv_flag(offv[2]),
		.ins_delay(offv[3]), .ov_flag(offv[4]), .health_flt(offv[5]), .oc_flag(oc),
		.ft_flag(ft), .local_fault(lf), .fault_clear(clr), .fet_on(fet), .ext_fault(ext));
	pfs_sec_model sec (.clk(clk), .line(line), .fault_cmd(sec_cmd), .pull(sec_pull),
		.sec_fet(sec_f));
	// ----
	// helpers
	// ----
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// bounded wait; a stuck fet counts as a mismatch
	task wait_fet(input logic v);
		int i;
		i = 0;
		while (fet !== v && i < 80)
		begin
			cyc(1);
			i++;
		end
		check(fet, v);
	endtask : wait_fet
	// enable cycle with clear, since latches need it
	task recover;
		offv = 7'h40;
		clr = 1;
		cyc(2);
		clr = 0;
		offv = 0;
		wait_fet(1);
	endtask : recover
	task wr_fn(input logic [1:0] v);
		fn_d = v;
		fn_wr = 1;
		cyc(1);
		fn_wr = 0;
		cyc(1);
		check(fn, v);
	endtask : wr_fn
	// ----
	// scenarios
	// ----
	task t_reset;
		check(fn, PFS_FN_RESET);
		check(refv, PFS_REF_RESET);
		check(fet, 0);
		check(oe, 1);
		recover;
		check(oe, 0);
		check(line, 1);
		check(sec_f, 1);
		$display("test reset_on done");
	endtask : t_reset
	task t_states;
		for (int k = 0; k < 7; k++)
		begin
			offv = 7'h01 << k;
			wait_fet(0);
			check(oe, 1);
			recover;
		end
		$display("test off_states done");
	endtask : t_states
	task t_oc;
		oc = 1;
		cyc(3);
		oc = 0;
		cyc(15);
		check(fet, 1);
		oc = 1;
		cyc(6);
		check(fet, 1);
		wait_fet(0);
		check(oe, 1);
		oc = 0;
		recover;
		$display("test overcurrent done");
	endtask : t_oc
	task t_ft;
		cfg = 16'h2000;
		ft = 1;
		cyc(1);
		ft = 0;
		wait_fet(0);
		check(oe, 1);
		wait_fet(1);
		check(oe, 0);
		cfg = 0;
		// without the one-shot bit the trip holds low only while it stands
		cyc(6);
		ft = 1;
		cyc(1);
		ft = 0;
		wait_fet(0);
		check(oe, 1);
		wait_fet(1);
		check(ext, 0);
		$display("test fast_trip done");
	endtask : t_ft
	task t_ext;
		sec_cmd = 1;
		wait_fet(0);
		check(ext, 1);
		sec_cmd = 0;
		cyc(10);
		check(line, 0);
		check(sec_f, 0);
		check(fet, 0);
		recover;
		check(ext, 0);
		$display("test external_fault done");
	endtask : t_ext
	task t_pin;
		wr_fn(PFS_FN_GPO);
		cyc(3);
		check(oe, 0);
		gpo = 0;
		cyc(3);
		check(oe, 1);
		wr_fn(PFS_FN_GPI);
		sec_cmd = 1;
		cyc(4);
		check(gpi, 0);
		sec_cmd = 0;
		cyc(4);
		check(gpi, 1);
		wr_fn(PFS_FN_SYNC);
		ref_d = 8'h3C;
		ref_wr = 1;
		cyc(1);
		ref_wr = 0;
		cyc(1);
		check(refv, 8'h3C);
		recover;
		$display("test pin_and_ref done");
	endtask : t_pin
	// secondary role: own fault latches off, a low line only turns off
	task t_sec;
		prim = 0;
		lf = 1;
		wait_fet(0);
		check(oe, 1);
		lf = 0;
		cyc(6);
		check(fet, 0);
		check(oe, 1);
		recover;
		sec_cmd = 1;
		wait_fet(0);
		check(ext, 0);
		sec_cmd = 0;
		wait_fet(1);
		prim = 1;
		$display("test secondary_role done");
	endtask : t_sec
	task stop_test;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// watchdog well past the expected run length
	initial
	begin
		#2000000;
		failures++;
		stop_test;
	end
	initial
	begin
		cyc(2);
		sys_rst = 0;
		t_reset;
		t_states;
		t_oc;
		t_ft;
		t_ext;
		t_pin;
		t_sec;
		stop_test;
	end
endmodule : pfs_sync_line_tb

// >>> core/pfs_input_sync.sv
// module: two-stage synchronisers for pin inputs and the off-condition summary
`timescale 1ns/1ps
module pfs_input_sync
	import pfs_pkg::*;
#(
	parameter int N_IN = 9
)(
	input  wire logic            clk,      // system clock
	input  wire logic            sys_rst,  // synchronous reset, active high
	input  wire logic            line_in,  // raw line level
	input  wire logic [N_IN-1:0] cond_in,  // raw off conditions
	pfs_pin_if.src               pin       // synchronised results
);
	import pfs_pkg::*;

	logic [N_IN:0] stage_a;
	logic [N_IN:0] stage_b;
	logic [N_IN:0] next_stage_a;
	logic [N_IN:0] next_stage_b;

	// ------------------------------------------------------------
	// two flops; first stage feeds the second only
	// ------------------------------------------------------------
	always_comb
	begin
		next_stage_a = {line_in, cond_in};
		next_stage_b = stage_a;
	end

	// line idles released-high, so reset to one
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stage_a <= {1'b1, {N_IN{1'b0}}};
			stage_b <= {1'b1, {N_IN{1'b0}}};
		end
		else
		begin
			stage_a <= next_stage_a;
			stage_b <= next_stage_b;
		end
	end

	assign pin.line_level = stage_b[N_IN];
	assign pin.off_fault  = |stage_b[N_IN-1:0];

endmodule : pfs_input_sync

// >>> core/pfs_pin_if.sv
// interface: carries the synchronised pin level and the fault summary between modules
`timescale 1ns/1ps
interface pfs_pin_if;
	logic line_level;   // synchronised level of the shared line
	logic off_fault;    // any cond_in condition; enable, overcurrent and fast-trip are kept out of it
	modport src (output line_level, output off_fault);
	modport dst (input line_level, input off_fault);
endinterface : pfs_pin_if

// >>> core/pfs_pkg.sv
// package: shared constants and types for the parallel sync line block
package pfs_pkg;

	// ------------------------------------------------------------
	// pin function selection for general_io_three
	// ------------------------------------------------------------
	localparam logic [1:0] PFS_FN_SYNC   = 2'h0;
	localparam logic [1:0] PFS_FN_GPO    = 2'h1;
	localparam logic [1:0] PFS_FN_GPI    = 2'h2;
	localparam logic [1:0] PFS_FN_RESET  = PFS_FN_SYNC;

	// ------------------------------------------------------------
	// configuration word field positions and reset values
	// ------------------------------------------------------------
	localparam int         PFS_CFG_W         = 16;
	localparam int         PFS_CFG_FT_ONESHOT = 13;
	localparam logic [15:0] PFS_CFG_RESET    = 16'h0000;
	localparam int         PFS_REF_W         = 8;
	localparam logic [7:0] PFS_REF_RESET     = 8'h80;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ             = 10_000_000;
	localparam int OC_BLANK_US        = 100;
	localparam int OC_BLANK_CYC       = (OC_BLANK_US * (CLK_HZ / 1_000_000) > 0)
		? OC_BLANK_US * (CLK_HZ / 1_000_000) : 1;
	localparam int FT_SHOT_US         = 10;
	localparam int FT_SHOT_CYC        = (FT_SHOT_US * (CLK_HZ / 1_000_000) > 0)
		? FT_SHOT_US * (CLK_HZ / 1_000_000) : 1;
	localparam int FT_OFF_US          = 1;
	localparam int FT_OFF_CYC         = (FT_OFF_US * (CLK_HZ / 1_000_000) > 0)
		? FT_OFF_US * (CLK_HZ / 1_000_000) : 1;
	localparam int PFS_TMR_W          = 16;

	// ------------------------------------------------------------
	// device states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PFS_ST_OFF     = 3'b000,
		PFS_ST_ON      = 3'b001,
		PFS_ST_OC_WAIT = 3'b010,
		PFS_ST_FT_OFF  = 3'b011,
		PFS_ST_FT_ON   = 3'b100,
		PFS_ST_LATCH   = 3'b101
	} pfs_state_t;

endpackage : pfs_pkg

// >>> core/pfs_sync_line.sv
// module: state handshake on the shared open-drain sync line of a paralleled switch
`timescale 1ns/1ps

// Operation
// [RQ1] the line is released high whenever the fet is meant to conduct, in inrush and steady state.
// [RQ2] a low line from any device switches the local fet off; in PFS_ST_FT_ON the code ignores the line until PFS_ST_ON.
// [RQ3] the line is both command and handshake so all devices switch together.
// [RQ4] a transient overcurrent keeps the fet on; one that outlasts the blanking timer trips it.
// [RQ5] with config bit 13 set a fast-trip one-shot runs, line low while off, high once back on.
// [RQ6] a secondary pulling the line low turns the fet off and the primary keeps holding it low; code latches only in PFS_ST_ON, not PFS_ST_OC_WAIT.
// [RQ7] the line is only ever pulled low or released; a pull-up makes the high level.
// [RQ8] general_io_three carries the sync function after reset and can be reassigned.
// [RQ9] the primary commands the secondaries through the line; secondaries report blocking faults on it.
// [RQ10] level transitions and timing keep all state machines aligned for a common start-up.
// [RQ11] fail-safe logic turns the whole chain off on a fault even without the primary.
// [RQ12] the shared current reference is set by host writes and may change while running.
// [RQ13] a secondary fault missed by the primary pulls the line low and latches off.
// [RQ14] the listed fault, disable and delay states turn the fet off and pull the line low.
module pfs_sync_line
	import pfs_pkg::*;
#(
	parameter int OC_BLANK = OC_BLANK_CYC,  // overcurrent_blanking_timer length
	parameter int FT_SHOT  = FT_SHOT_CYC,   // on part of the fast-trip one-shot, after FT_OFF
	parameter int FT_OFF   = FT_OFF_CYC     // off part of the one-shot
)(
	input  wire logic                  clk,             // system clock
	input  wire logic                  sys_rst,         // synchronous reset, active high
	input  wire logic                  is_primary,      // strap: primary role
	input  wire logic                  io3_in,          // pin level of general_io_three
	output logic                       io3_out,         // pin drive value (always low)
	output logic                       io3_oe,          // pin pull-down enable
	input  wire logic [1:0]            io3_fn_wr_data,  // new pin function
	input  wire logic                  io3_fn_wr,       // pin config write strobe
	output logic [1:0]                 io3_fn,          // current pin function
	input  wire logic                  io3_gpo,         // general output value when reassigned
	output logic                       io3_gpi,         // general input value when reassigned
	input  wire logic [15:0]           cfg_word,        // device configuration word
	input  wire logic [7:0]            ref_wr_data,     // reference setting write data
	input  wire logic                  ref_wr,          // reference write strobe
	output logic [7:0]                 shared_current_reference_setting, // dac code
	input  wire logic                  en_ok,           // enable above threshold
	input  wire logic                  ot_flag,         // overtemperature
	input  wire logic                  retry_run,       // auto-retry timer running
	input  wire logic                  uv_flag,         // input or supply undervoltage
	input  wire logic                  ins_delay,       // insertion delay running
	input  wire logic                  ov_flag,         // input overvoltage
	input  wire logic                  health_flt,      // fet health fault
	input  wire logic                  oc_flag,         // overcurrent above threshold
	input  wire logic                  ft_flag,         // fast-trip detect
	input  wire logic                  local_fault,     // secondary-side fault detect
	input  wire logic                  fault_clear,     // power or enable cycle clears latch
	output logic                       fet_on,          // fet driver command
	output logic                       ext_fault        // external fault latched
);
	import pfs_pkg::*;

	pfs_pin_if pin ();

	// ------------------------------------------------------------
	// synchronise pin and asynchronous condition flags
	// ------------------------------------------------------------
	// fast-trip and overcurrent stay separate; they drive state timing
	logic [8:0] raw_cond;
	logic [1:0] oc_ft_a;
	logic [1:0] oc_ft_b;
	logic [1:0] next_oc_ft_a;
	logic       en_a;
	logic       en_b;
	logic       next_en_a;
	// local fault gets its own pair so the latch decision never reads a raw pin
	logic       lf_a;
	logic       lf_b;
	logic       next_lf_a;

	assign raw_cond = {local_fault, health_flt, ov_flag, ins_delay, uv_flag,
		retry_run, ot_flag, 1'b0, 1'b0};

	pfs_input_sync #(.N_IN(9)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.line_in (io3_in),
		.cond_in (raw_cond),
		.pin     (pin)
	);

	always_comb
	begin
		next_oc_ft_a = {oc_flag, ft_flag};
		next_en_a    = en_ok;
		next_lf_a    = local_fault;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			oc_ft_a <= 2'h0;
			oc_ft_b <= 2'h0;
			en_a    <= 1'b0;
			en_b    <= 1'b0;
			lf_a    <= 1'b0;
			lf_b    <= 1'b0;
		end
		else
		begin
			oc_ft_a <= next_oc_ft_a;
			oc_ft_b <= oc_ft_a;
			en_a    <= next_en_a;
			en_b    <= en_a;
			lf_a    <= next_lf_a;
			lf_b    <= lf_a;
		end
	end

	// ------------------------------------------------------------
	// pin function and reference setting
	// ------------------------------------------------------------
	logic [1:0] next_io3_fn;
	logic [7:0] next_ref;
	logic       sync_sel;

	always_comb
	begin
		next_io3_fn = io3_fn_wr ? io3_fn_wr_data : io3_fn;  // [RQ8]
		next_ref    = ref_wr ? ref_wr_data : shared_current_reference_setting;  // [RQ12]
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			io3_fn                           <= PFS_FN_RESET;  // [RQ8]
			shared_current_reference_setting <= PFS_REF_RESET;
		end
		else
		begin
			io3_fn                           <= next_io3_fn;
			shared_current_reference_setting <= next_ref;
		end
	end

	assign sync_sel = (io3_fn == PFS_FN_SYNC);

	// ------------------------------------------------------------
	// device state machine
	// ------------------------------------------------------------
	pfs_state_t           state;
	pfs_state_t           next_state;
	logic [PFS_TMR_W-1:0] tmr;
	logic [PFS_TMR_W-1:0] next_tmr;
	logic                 next_ext_fault;
	logic                 line_low;
	logic                 force_off;
	logic                 drive_low;
	logic                 ready;
	logic                 own_quiet;
	logic                 ext_low;
	logic                 oe_d1;
	logic                 oe_d2;

	// line only counts when the pin carries the sync function
	assign line_low  = sync_sel && !pin.line_level;  // [RQ2]
	assign force_off = pin.off_fault || !en_b;  // [RQ14]
	// a trip cause that still stands keeps the line held low
	assign ready     = !force_off && !oc_ft_b[0] && !oc_ft_b[1];  // [RQ4] [RQ5]
	// own pull needs two syncing edges to leave the line level; wait it out
	assign own_quiet = !sync_sel || (!io3_oe && !oe_d1 && !oe_d2);  // [RQ3]
	assign ext_low   = line_low && own_quiet;  // [RQ2] [RQ6]

	always_comb
	begin
		next_state     = state;
		next_tmr       = tmr;
		next_ext_fault = ext_fault;
		case (state)
			PFS_ST_OFF:
			begin
				// all devices leave off together on the released line
				if (ready && !ext_fault && !line_low && own_quiet)  // [RQ3] [RQ10]
					next_state = PFS_ST_ON;
			end
			PFS_ST_ON:
			begin
				next_tmr = '0;
				if (force_off)  // [RQ14]
					next_state = PFS_ST_OFF;
				else if (oc_ft_b[0])
				begin
					next_state = cfg_word[PFS_CFG_FT_ONESHOT] ? PFS_ST_FT_OFF : PFS_ST_OFF;  // [RQ5]
				end
				else if (ext_low)
				begin
					// another device pulled low: primary latches it  [RQ6] [RQ9]
					next_state = PFS_ST_OFF;
					if (is_primary)
						next_ext_fault = 1'b1;  // [RQ6]
				end
				else if (oc_ft_b[1])
					next_state = PFS_ST_OC_WAIT;  // [RQ4]
			end
			PFS_ST_OC_WAIT:
			begin
				next_tmr = tmr + 1'b1;
				if (force_off || ext_low)
					next_state = PFS_ST_OFF;  // [RQ2]
				else if (!oc_ft_b[1])
					next_state = PFS_ST_ON;  // transient overcurrent  [RQ4]
				else if (tmr >= PFS_TMR_W'(OC_BLANK - 1))
					next_state = PFS_ST_OFF;  // circuit-breaker trip  [RQ4]
			end
			PFS_ST_FT_OFF:
			begin
				next_tmr = tmr + 1'b1;
				if (force_off)
					next_state = PFS_ST_OFF;
				else if (tmr >= PFS_TMR_W'(FT_OFF - 1))
					next_state = PFS_ST_FT_ON;  // [RQ5]
			end
			PFS_ST_FT_ON:
			begin
				next_tmr = tmr + 1'b1;
				if (force_off)
					next_state = PFS_ST_OFF;
				else if (tmr >= PFS_TMR_W'(FT_SHOT - 1))
					next_state = PFS_ST_ON;
			end
			PFS_ST_LATCH:
			begin
				// secondary latches off until power or enable cycle  [RQ13] [RQ11]
				if (fault_clear)
					next_state = PFS_ST_OFF;
			end
			default:
				next_state = PFS_ST_OFF;
		endcase
		// a missed secondary fault latches off from any state  [RQ13]
		if (!is_primary && lf_b && state != PFS_ST_LATCH)
			next_state = PFS_ST_LATCH;
		if (fault_clear)
		begin
			next_ext_fault = next_ext_fault && !ext_fault;  // a capture in this cycle wins
			if (state != PFS_ST_LATCH)
				next_state = PFS_ST_OFF;
		end
		if (state != next_state && next_state != PFS_ST_OC_WAIT)
			next_tmr = '0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state     <= PFS_ST_OFF;
			tmr       <= '0;
			ext_fault <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			tmr       <= next_tmr;
			ext_fault <= next_ext_fault;
		end
	end

	// ------------------------------------------------------------
	// pin drive: pull-down only, released when fet should conduct
	// ------------------------------------------------------------
	logic fet_cmd;
	logic next_fet_on;
	logic next_io3_oe;
	logic next_gpi;

	assign fet_cmd   = (next_state == PFS_ST_ON) || (next_state == PFS_ST_OC_WAIT)
		|| (next_state == PFS_ST_FT_ON);  // [RQ1] [RQ4] [RQ5]
	// a ready idle device lets go, so the chain only rises once every device agrees
	assign drive_low = !fet_cmd
		&& !((next_state == PFS_ST_OFF) && ready && !next_ext_fault);  // [RQ6] [RQ14]

	always_comb
	begin
		next_fet_on = fet_cmd;  // [RQ2]
		if (sync_sel)
			next_io3_oe = drive_low;  // [RQ7] [RQ11]
		else if (io3_fn == PFS_FN_GPO)
			next_io3_oe = !io3_gpo;
		else
			next_io3_oe = 1'b0;
		next_gpi = pin.line_level;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			fet_on  <= 1'b0;
			io3_oe  <= 1'b1;  // hold line low until state known
			io3_gpi <= 1'b1;
			io3_out <= 1'b0;
			oe_d1   <= 1'b1;
			oe_d2   <= 1'b1;
		end
		else
		begin
			fet_on  <= next_fet_on;
			io3_oe  <= next_io3_oe;
			io3_gpi <= next_gpi;
			oe_d1   <= io3_oe;  // own drive delayed to match the pin synchroniser
			oe_d2   <= oe_d1;
			io3_out <= 1'b0;  // open drain: never drives high  [RQ7]
		end
	end

endmodule : pfs_sync_line
